// ### verilog/ofl_top.sv
// Outlier filter and emitter configuration block with APB registers.
// Assumes samples arrive with valid/ready; downstream may stall the FIFO.
// How it works
// - Outlier processing runs only while the enable bit is set; it resets off.
// - Order bit 0 predicts from the last sample, 1 fits a line to four (reset).
// - Deviation tracker coefficient is 1/64, 1/32, 1/16, 1/8 for codes 0..3.
// - Deviation estimate starts at 64, 48, 32 or 24, scaled with ADC range.
// - An outlier is a difference above deviation times 4, 8, 16 or 32.
// - Six 4-bit slot type fields, two per register, odd slot low, reset zero.
// - Emitter current is drive code times a range step of 0.12 to 0.48 mA.
// - In proximity or multi-emitter mode the probe code sets the current.
// - The probe code uses each emitter's own range field and step.
module ofl_top #(
  parameter int SAMPLE_WIDTH = ofl_pkg::SAMPLE_W,
  parameter int DEPTH = ofl_pkg::FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [1:0] adc_range,
  input wire logic smp_valid,
  output logic smp_ready,
  input wire logic [SAMPLE_WIDTH-1:0] smp_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [SAMPLE_WIDTH-1:0] out_data,
  output logic out_replaced,
  output logic [23:0] slot_types,
  output logic [7:0] emitter1_code,
  output logic [7:0] emitter2_code,
  output logic [7:0] emitter3_code,
  output logic [17:0] emitter1_ua,
  output logic [17:0] emitter2_ua,
  output logic [17:0] emitter3_ua
);
  import ofl_pkg::*;
  localparam int W = SAMPLE_WIDTH;
  if (W < 8 || W > 24) begin : g_bad_width
    $error("ofl_top: sample width out of range");
  end
  typedef struct packed {
    logic [7:0] filt;
    logic [7:0] s12;
    logic [7:0] s34;
    logic [7:0] s56;
    logic [7:0] e1;
    logic [7:0] e2;
    logic [7:0] e3;
    logic [7:0] probe;
    logic [7:0] range;
    logic [1:0] mode;
    ofl_state_t st;
    logic [W-1:0] cur;
    logic [3:0][W-1:0] hist;
    logic [2:0] nhist;
    logic [W+7:0] dev;
    logic [W-1:0] pred;
    logic [W-1:0] res;
    logic res_v;
    logic res_rep;
    logic [15:0] outliers;
    logic [7:0] rdat;
    logic rdy;
    logic [17:0] ua1;
    logic [17:0] ua2;
    logic [17:0] ua3;
  } ofl_st_t;
  ofl_st_t q;
  ofl_st_t d;
  logic fifo_ready;
  logic [W:0] fifo_in;
  logic [W:0] fifo_out;

  function automatic logic [7:0] idx_of(input logic [11:0] a);
    return a[9:2];
  endfunction

  // Current in microamps: code times range step
  function automatic logic [17:0] cur_ua(input logic [7:0] code,
                                         input logic [1:0] rg);
    logic [9:0] step;
    step = STEP_UA * (10'(rg) + 10'h001);
    return 18'(code) * 18'(step);
  endfunction

  function automatic logic [W+7:0] init_dev(input logic [1:0] c,
                                            input logic [1:0] rg);
    logic [7:0] v;
    v = 8'h40;
    case (c)
      2'h0: v = 8'h40;
      2'h1: v = 8'h30;
      2'h2: v = 8'h20;
      default: v = 8'h18;
    endcase
    // Each step of the range code doubles the starting estimate
    return (W+8)'(v) << rg;
  endfunction

  logic apb_acc;
  logic [1:0] rg1;
  logic [1:0] rg2;
  logic [1:0] rg3;
  logic use_probe;
  logic wr_go;
  logic [W+2:0] lin;
  logic [W-1:0] diff;
  logic [W+7:0] thr;
  logic [2:0] tcs;

  assign apb_acc = psel && penable;
  // One wait state, so that read data stands in a flop before pready
  assign pready = q.rdy;
  assign wr_go = apb_acc && pwrite && q.rdy;
  assign smp_ready = (q.st == OFL_IDLE) && !q.res_v;
  assign rg1 = q.range[1:0];
  assign rg2 = q.range[3:2];
  assign rg3 = q.range[5:4];
  assign use_probe = q.mode[BIT_PROXIMITY_MODE] || q.mode[BIT_MULTI];

  always_comb begin
    d = q;
    pslverr = 1'b0;
    lin = '0;
    diff = '0;
    thr = '0;
    tcs = TC_SHIFT_BASE - 3'(q.filt[POS_TC+:2]);
    d.rdy = apb_acc && !q.rdy;
    if (apb_acc) begin
      if (idx_of(paddr) == IDX_FILTER) begin
        d.rdat = q.filt;
        if (wr_go) begin
          d.filt = pwdata[7:0];
          // Restart the deviation estimate with the new settings
          d.dev = init_dev(pwdata[POS_INIT+:2], adc_range);
        end
      end else if (idx_of(paddr) == IDX_SLOTS12) begin
        d.rdat = q.s12;
        if (wr_go) d.s12 = pwdata[7:0];
      end else if (idx_of(paddr) == IDX_SLOTS34) begin
        d.rdat = q.s34;
        if (wr_go) d.s34 = pwdata[7:0];
      end else if (idx_of(paddr) == IDX_SLOTS56) begin
        d.rdat = q.s56;
        if (wr_go) d.s56 = pwdata[7:0];
      end else if (idx_of(paddr) == IDX_EM1) begin
        d.rdat = q.e1;
        if (wr_go) d.e1 = pwdata[7:0];
      end else if (idx_of(paddr) == IDX_EM2) begin
        d.rdat = q.e2;
        if (wr_go) d.e2 = pwdata[7:0];
      end else if (idx_of(paddr) == IDX_EM3) begin
        d.rdat = q.e3;
        if (wr_go) d.e3 = pwdata[7:0];
      end else if (idx_of(paddr) == IDX_PROBE) begin
        d.rdat = q.probe;
        if (wr_go) d.probe = pwdata[7:0];
      end else if (idx_of(paddr) == IDX_RANGE) begin
        d.rdat = {2'b00, q.range[5:0]};
        if (wr_go) d.range = {2'b00, pwdata[5:0]};
      end else if (idx_of(paddr) == IDX_MODE) begin
        d.rdat = {6'h00, q.mode};
        if (wr_go) d.mode = pwdata[1:0];
      end else if (idx_of(paddr) == IDX_STATUS) begin
        d.rdat = q.outliers[7:0];
      end else begin
        d.rdat = 8'h00;
        pslverr = q.rdy;
      end
    end
    // Emitter currents: probe code replaces the drive code in those modes
    d.ua1 = cur_ua(use_probe ? q.probe : q.e1, rg1);
    d.ua2 = cur_ua(use_probe ? q.probe : q.e2, rg2);
    d.ua3 = cur_ua(use_probe ? q.probe : q.e3, rg3);
    if (q.res_v && fifo_ready) d.res_v = 1'b0;
    case (q.st)
      OFL_IDLE: begin
        if (smp_valid && smp_ready) begin
          d.cur = smp_data;
          d.st = q.filt[BIT_ENABLE] ? OFL_PRED : OFL_DECIDE;
        end
      end
      OFL_PRED: begin
        // Line through four points, extrapolated one step ahead
        // Least-squares fit gives newest + (second - fourth) / 2
        lin = (W+3)'({q.hist[0], 1'b0}) + (W+3)'(q.hist[1])
            - (W+3)'(q.hist[3]);
        if (q.filt[BIT_ORDER] && q.nhist == 3'h4) begin
          d.pred = W'($signed(lin) >>> 1);
        end else begin
          d.pred = q.hist[0];
        end
        if (q.nhist == 3'h0) d.dev = init_dev(q.filt[POS_INIT+:2],
                                             adc_range);
        d.st = OFL_DECIDE;
      end
      default: begin
        d.res_rep = 1'b0;
        d.res = q.cur;
        if (q.filt[BIT_ENABLE] && q.nhist != 3'h0) begin
          diff = (q.cur > q.pred) ? q.cur - q.pred : q.pred - q.cur;
          thr = q.dev << (3'(q.filt[POS_GAIN+:2]) + GAIN_SHIFT_BASE);
          if ((W+8)'(diff) > thr) begin
            d.res = q.pred;
            d.res_rep = 1'b1;
            d.outliers = q.outliers + 16'h0001;
            // Deviation tracks the replaced stream, so it sees no error
            diff = '0;
          end
          d.dev = q.dev - (q.dev >> tcs) + ((W+8)'(diff) >> tcs);
        end
        // Replaced sample feeds the history as well
        d.hist = {q.hist[2:0], d.res};
        if (q.nhist != 3'h4) d.nhist = q.nhist + 3'h1;
        d.res_v = 1'b1;
        d.st = OFL_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '0;
      q.filt <= RST_FILTER;
      q.st <= OFL_IDLE;
    end else begin
      q <= d;
    end
  end

  assign fifo_in = {q.res_rep, q.res};
  assign prdata = {24'h000000, q.rdat};
  assign slot_types = {q.s56, q.s34, q.s12};
  assign emitter1_code = q.e1;
  assign emitter2_code = q.e2;
  assign emitter3_code = q.e3;
  assign emitter1_ua = q.ua1;
  assign emitter2_ua = q.ua2;
  assign emitter3_ua = q.ua3;
  assign out_data = fifo_out[W-1:0];
  assign out_replaced = fifo_out[W];

  ofl_fifo #(.WIDTH(W+1), .DEPTH(DEPTH)) u_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(q.res_v),
    .in_ready(fifo_ready),
    .in_data(fifo_in),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_data(fifo_out)
  );
endmodule

// ### verilog/ofl_pkg.sv
// Package for the outlier filter and emitter configuration block.
// Assumes an APB slave with 32-bit data and one word per register.
package ofl_pkg;
  // Register indices as printed; byte address is four times the index
  localparam logic [7:0] IDX_FILTER = 8'h16;
  localparam logic [7:0] IDX_SLOTS12 = 8'h20;
  localparam logic [7:0] IDX_SLOTS34 = 8'h21;
  localparam logic [7:0] IDX_SLOTS56 = 8'h22;
  localparam logic [7:0] IDX_EM1 = 8'h23;
  localparam logic [7:0] IDX_EM2 = 8'h24;
  localparam logic [7:0] IDX_EM3 = 8'h25;
  localparam logic [7:0] IDX_PROBE = 8'h29;
  localparam logic [7:0] IDX_RANGE = 8'h2a;
  localparam logic [7:0] IDX_MODE = 8'h40;
  localparam logic [7:0] IDX_STATUS = 8'h41;
  // Filter register fields
  localparam int BIT_ENABLE = 7;
  localparam int BIT_ORDER = 6;
  localparam int POS_TC = 4;
  localparam int POS_INIT = 2;
  localparam int POS_GAIN = 0;
  localparam logic [7:0] RST_FILTER = 8'h40;
  localparam logic [7:0] RST_ZERO = 8'h00;
  // Mode register bits
  localparam int BIT_PROXIMITY_MODE = 0;
  localparam int BIT_MULTI = 1;
  // Deviation filter shift for tc code 0 (1/64)
  localparam logic [2:0] TC_SHIFT_BASE = 3'h6;
  // Threshold gain shift for code 0 (x4)
  localparam logic [2:0] GAIN_SHIFT_BASE = 3'h2;
  // Current step in microamps per range code, 0.12 mA for code 0
  localparam logic [9:0] STEP_UA = 10'h078;
  localparam int SAMPLE_W = 19;
  localparam int FIFO_DEPTH = 32;
  typedef enum logic [1:0] {
    OFL_IDLE = 2'b00,
    OFL_PRED = 2'b01,
    OFL_DECIDE = 2'b11
  } ofl_state_t;
endpackage

// ### verilog/ofl_fifo.sv
// FIFO with valid/ready on both sides.
// Assumes one clock; rst asynchronous active high.
module ofl_fifo #(
  parameter int WIDTH = 19,
  parameter int DEPTH = 32
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad_cfg
    $error("ofl_fifo: depth must be a power of two, at least 2");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wp_q;
  logic [AW:0] rp_q;
  logic push;
  logic pop;
  assign in_ready = (wp_q - rp_q) != (AW+1)'(DEPTH);
  assign out_valid = wp_q != rp_q;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rp_q[AW-1:0]];
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      if (push) begin
        wp_q <= wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= rp_q + 1'b1;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_q[AW-1:0]] <= in_data;
    end
  end
endmodule

// ### tb/ofl_checker.sv
// Assertions on the ports of the outlier filter configuration block.
// Assumes a bind to ofl_top; register index is paddr[9:2].
module ofl_checker import ofl_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic smp_valid,
  input wire logic smp_ready,
  input wire logic out_valid,
  input wire logic out_replaced,
  input wire logic [23:0] slot_types,
  input wire logic [7:0] emitter2_code,
  input wire logic [17:0] emitter1_ua,
  input wire logic [17:0] emitter2_ua
);
  logic wr;
  logic en_q;
  logic [7:0] ix;
  logic [7:0] probe_q;
  logic [1:0] mode_q;
  assign ix = paddr[9:2];
  assign wr = psel && penable && pwrite && pready;
  // Shadows of the mode, probe code and enable settings
  always_ff @(posedge clk or posedge rst)
    if (rst) mode_q <= 2'h0;
    else if (wr && ix == IDX_MODE) mode_q <= pwdata[1:0];
  always_ff @(posedge clk or posedge rst)
    if (rst) probe_q <= 8'h00;
    else if (wr && ix == IDX_PROBE) probe_q <= pwdata[7:0];
  always_ff @(posedge clk or posedge rst)
    if (rst) en_q <= 1'b0;
    else if (wr && ix == IDX_FILTER) en_q <= pwdata[BIT_ENABLE];
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_hold; !wr |=> $stable(slot_types); endproperty
  a_hold: assert property (p_hold) else $error("slots moved");
  property p_slot; wr && ix == IDX_SLOTS34 |=>
    slot_types[15:8] == $past(pwdata[7:0]); endproperty
  a_slot: assert property (p_slot) else $error("slot write");
  property p_em; wr && ix == IDX_EM2 |=>
    emitter2_code == $past(pwdata[7:0]); endproperty
  a_em: assert property (p_em) else $error("drive write");
  property p_step; emitter1_ua % 120 == 0; endproperty
  a_step: assert property (p_step) else $error("current step");
  property p_zero; (mode_q == 2'h0 && emitter2_code == 8'h00)[*2]
    |-> emitter2_ua == 18'h0; endproperty
  a_zero: assert property (p_zero) else $error("zero code");
  property p_probe; (mode_q != 2'h0 && probe_q == 8'h00)[*2]
    |-> emitter1_ua == 18'h0; endproperty
  a_probe: assert property (p_probe) else $error("probe code");
  property p_en; out_valid && out_replaced |-> en_q; endproperty
  a_en: assert property (p_en) else $error("replaced while off");
  property p_smp; smp_valid && smp_ready |=> !smp_ready[*2]; endproperty
  a_smp: assert property (p_smp) else $error("sample spacing");
  property p_rdy; pready |-> psel && penable; endproperty
  a_rdy: assert property (p_rdy) else $error("ready outside access");
  c_rep: cover property (out_valid && out_replaced);
  c_err: cover property (psel && penable && pslverr);
  c_full: cover property (smp_valid && !smp_ready);
endmodule

// ### tb/ofl_top_bench.sv
// Bench for the outlier filter configuration block, with a queue model.
// Assumes ofl_top with APB registers and the sample stream ports.
module ofl_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import ofl_pkg::*;
  logic clk = '0, rst = '1, psel = '0, penable = '0, pwrite = '0, er, acc;
  logic smp_valid = '0, out_ready = '0, hold = '0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd, w;
  logic [1:0] adc_range = 2'h3;
  logic [18:0] smp_data = '0, out_data;
  logic pready, pslverr, smp_ready, out_valid, out_replaced;
  logic [23:0] slot_types;
  logic [7:0] ec [1:3], v [8], ix [8];
  logic [17:0] ua [1:3];
  int errors = 0, n_compared = 0, seed = 32'h05e6, hist[$], mq[$];
  ofl_top ofl_top_i (.clk, .rst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .adc_range, .smp_valid,
    .smp_ready, .smp_data, .out_valid, .out_ready, .out_data,
    .out_replaced, .slot_types, .emitter1_code(ec[1]),
    .emitter2_code(ec[2]), .emitter3_code(ec[3]), .emitter1_ua(ua[1]),
    .emitter2_ua(ua[2]), .emitter3_ua(ua[3]));
  task automatic chk(input string s, input logic [31:0] g, e);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("Error at %0t %s: got %h expected %h", $time, s, g, e);
    end
  endtask
  task automatic final_report;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic apb(input bit wr, input logic [7:0] i, logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'h0, i, 2'h0};
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    er = pslverr;
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic send(input int x, input bit en, ord, input int lim);
    int n = 0;
    int p = x;
    if (hist.size() > 3)
      p = ord ? hist[$] + ((hist[$-1] - hist[$-3]) >>> 1) : hist[$];
    p = (en && x - p > 200000) ? p + 2**19 : x;
    smp_valid <= 1'b1;
    smp_data <= 19'(x);
    @(posedge clk);
    while (smp_ready !== 1'b1 && n++ < lim) @(posedge clk);
    acc = n <= lim;
    smp_valid <= 1'b0;
    if (acc) begin
      mq.push_back(p);
      hist.push_back(p % 2**19);
    end
    @(posedge clk);
  endtask
  task automatic drain;
    int n = 0;
    while (mq.size() > 0 && n++ < 3000) @(posedge clk);
    chk("drained", mq.size(), 0);
  endtask
  always @(negedge clk)
    if (out_valid === 1'b1 && out_ready === 1'b1)
      chk("sample", {out_replaced, out_data},
        mq.size() ? mq.pop_front() : -1);
  always @(posedge clk) out_ready <= !hold && $random(seed) % 3 != 0;
  initial begin
    forever #12.5 clk = ~clk;
  end
  initial begin
    #(25 * 20000);
    errors++;
    final_report;
  end
  initial begin
    int n;
    ix = '{IDX_FILTER, IDX_SLOTS12, IDX_SLOTS34, IDX_SLOTS56,
      IDX_EM1, IDX_EM2, IDX_EM3, IDX_PROBE};
    adc_range <= 2'($random(seed));
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int k = 0; k < 8; k++) begin
      apb(0, ix[k], 0);
      chk("reset value", rd, k ? 0 : RST_FILTER);
    end
    for (int k = 0; k < 8; k++) begin
      w = $random(seed);
      v[k] = w[7:0];
      apb(1, ix[k], w);
      apb(0, ix[k], 0);
      chk("readback", rd, v[k]);
    end
    chk("slot types", slot_types, {v[3], v[2], v[1]});
    for (int k = 1; k < 4; k++)
      chk("drive code", ec[k], v[3 + k]);
    apb(0, 8'h30, 0);
    chk("unmapped error", er, 1);
    chk("unmapped data", rd, 0);
    $display("test registers done");
    w = $random(seed);
    apb(1, IDX_RANGE, w);
    for (int m = 0; m < 4; m++) begin
      apb(1, IDX_MODE, m);
      repeat (2) @(posedge clk);
      for (int k = 1; k < 4; k++)
        chk("current", ua[k], (m ? v[7] : v[3 + k]) * 120
          * (w[2 * k - 2 +: 2] + 1));
    end
    apb(1, IDX_PROBE, 0);
    repeat (2) @(posedge clk);
    chk("probe zero", ua[2], 0);
    apb(1, IDX_MODE, 0);
    $display("test currents done");
    for (int k = 0; k < 5; k++) begin
      w = {k < 4, k[0], k[1:0], k[1:0], k[1:0]};
      apb(1, IDX_FILTER, w);
      for (int j = 0; j < 9; j++) begin
        send(j < 4 ? 1000 : j < 7 ? 985 + 5 * j : j < 8 ? 401000 : 1020,
          w[7], w[6], 100);
        chk("accepted", acc, 1);
      end
      drain();
      $display("test filter pass %0d done", k);
    end
    hold <= 1'b1;
    n = 0;
    acc = 1'b1;
    while (acc && n < 60) begin
      send(1000, 0, 0, 20);
      n += acc;
    end
    chk("filled", n >= FIFO_DEPTH && n < 60, 1);
    hold <= 1'b0;
    drain();
    $display("test buffer done");
    final_report;
  end
endmodule
bind ofl_top ofl_checker ofl_checker_i (.clk, .rst, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pready, .pslverr, .smp_valid, .smp_ready,
  .out_valid, .out_replaced, .slot_types, .emitter2_code, .emitter1_ua,
  .emitter2_ua);
